/* verif/ctm_compact_timer_bench.sv */
// Testbench: register, pin and compare scenarios for the compact timer
module ctm_compact_timer_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk;
  logic sys_rst;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_write;
  logic reg_read;
  logic [7:0] reg_rdata;
  logic high_clock_tick;
  logic sub_clock_tick;
  logic ext_count_input;
  logic timer_out;
  logic timer_out_inverted;
  logic match_a_request;
  logic match_p_request;
  logic rd_seen = 1'b0;
  logic [15:0] note;
  logic [15:0] exp_q[$];
  logic [9:0] v;
  logic [1:0] act;
  logic init;
  int n_fail = 0;
  int n_checks = 0;
  int a_cnt = 0;
  int p_cnt = 0;
  int a0;
  int p0;
  int w[6] = '{200, 50, 1600, 6400, 200, 200};
  ctm_compact_timer ctm_compact_timer_i (
    .ref_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .high_clock_tick, .sub_clock_tick, .ext_count_input, .timer_out, .timer_out_inverted,
    .match_a_request, .match_p_request);
  ctm_pin_model ctm_pin_model_i (.ref_clk, .ext_count_input, .high_clock_tick, .sub_clock_tick);
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [7:0] e, input logic [7:0] got);
    n_checks++;
    if (got !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, e, got);
    end
  endtask : check
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge ref_clk);
    reg_write <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
    exp_q.push_back({m, e});
    @(posedge ref_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge ref_clk);
    reg_read <= 1'b0;
  endtask : rd
  // High first so the low byte comes from the latched buffer
  task automatic cnt(input logic [7:0] e, input logic [7:0] m = 8'hFF);
    rd(ctm_pkg::COUNTER_HIGH_OFS, 8'h00);
    rd(ctm_pkg::COUNTER_LOW_OFS, e, m);
  endtask : cnt
  task automatic pin_chk(input logic e);
    @(negedge ref_clk);
    check("timer_out", {7'h00, e}, {7'h00, timer_out});
  endtask : pin_chk
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish
  // ----------------------------------------
  // Result watcher
  // ----------------------------------------
  always @(posedge ref_clk) begin
    rd_seen <= reg_read;
    a_cnt <= a_cnt + int'(match_a_request === 1'b1);
    p_cnt <= p_cnt + int'(match_p_request === 1'b1);
  end
  always @(negedge ref_clk) begin
    if (rd_seen === 1'b1) begin
      note = exp_q.pop_front();
      check("reg_rdata", note[7:0], reg_rdata & note[15:8]);
    end
  end
  initial begin
    repeat (30000) @(posedge ref_clk);
    n_fail++;
    tally_and_finish();
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    sys_rst = 1'b1;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read = 1'b0;
    void'($urandom(32'h284e));
    repeat (20) @(posedge ref_clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 8; i++) rd(3'(i), 8'h00);
    $display("reset values done");
    for (int i = 0; i < 4; i++) begin
      wr(ctm_pkg::MODE_OUTPUT_CONTROL_OFS, {2'(i), 6'h15});
      rd(ctm_pkg::MODE_OUTPUT_CONTROL_OFS, {2'(i), 6'h15});
      if (i == 2) pin_chk(1'b1);
    end
    wr(ctm_pkg::MODE_OUTPUT_CONTROL_OFS, 8'h00);
    for (int i = 0; i < 2; i++) begin
      v = 10'($urandom);
      wr(ctm_pkg::MATCH_A_LOW_OFS, v[7:0]);
      wr(ctm_pkg::MATCH_A_HIGH_OFS, {6'h00, v[9:8]});
      wr(ctm_pkg::MATCH_A_LOW_OFS, ~v[7:0]);
      rd(ctm_pkg::MATCH_A_HIGH_OFS, {6'h00, v[9:8]});
      rd(ctm_pkg::MATCH_A_LOW_OFS, v[7:0]);
    end
    wr(ctm_pkg::COUNTER_LOW_OFS, 8'hFF);
    cnt(8'h00);
    $display("buffered access done");
    wr(ctm_pkg::CLOCK_ENABLE_CONTROL_OFS, 8'h68);
    ctm_pin_model_i.pulses(5);
    cnt(8'h05);
    wr(ctm_pkg::CLOCK_ENABLE_CONTROL_OFS, 8'hE8);
    ctm_pin_model_i.pulses(3);
    cnt(8'h05);
    wr(ctm_pkg::CLOCK_ENABLE_CONTROL_OFS, 8'h68);
    ctm_pin_model_i.pulses(2);
    cnt(8'h07);
    wr(ctm_pkg::CLOCK_ENABLE_CONTROL_OFS, 8'h60);
    ctm_pin_model_i.pulses(2);
    cnt(8'h07);
    wr(ctm_pkg::CLOCK_ENABLE_CONTROL_OFS, 8'h78);
    cnt(8'h00);
    ctm_pin_model_i.pulses(4);
    cnt(8'h04);
    $display("pin counting done");
    wr(ctm_pkg::MATCH_A_LOW_OFS, 8'h03);
    wr(ctm_pkg::MATCH_A_HIGH_OFS, 8'h00);
    a0 = a_cnt;
    p0 = p_cnt;
    for (int i = 0; i < 8; i++) begin
      act = 2'(i >> 1);
      init = i[0];
      wr(ctm_pkg::CLOCK_ENABLE_CONTROL_OFS, 8'h60);
      wr(ctm_pkg::MODE_OUTPUT_CONTROL_OFS, {2'b00, act, init, 3'b001});
      wr(ctm_pkg::CLOCK_ENABLE_CONTROL_OFS, 8'h68);
      repeat (3) @(posedge ref_clk);
      pin_chk(init);
      ctm_pin_model_i.pulses(3);
      pin_chk(act == ctm_pkg::ACTION_NONE ? init : act == ctm_pkg::ACTION_LOW ? 1'b0 :
        act == ctm_pkg::ACTION_HIGH ? 1'b1 : ~init);
      check("match_a_count", 8'(i + 1), 8'(a_cnt - a0));
      cnt(8'h00);
    end
    check("match_p_count", 8'h00, 8'(p_cnt - p0));
    $display("compare output done");
    wr(ctm_pkg::CLOCK_ENABLE_CONTROL_OFS, 8'h10);
    wr(ctm_pkg::MODE_OUTPUT_CONTROL_OFS, 8'h00);
    wr(ctm_pkg::MATCH_A_LOW_OFS, 8'h00);
    wr(ctm_pkg::MATCH_A_HIGH_OFS, 8'h00);
    wr(ctm_pkg::FLAG_STATUS_OFS, 8'h03);
    a0 = a_cnt;
    p0 = p_cnt;
    wr(ctm_pkg::CLOCK_ENABLE_CONTROL_OFS, 8'h19);
    repeat (120) @(posedge ref_clk);
    check("match_p_count", 8'h00, 8'(p_cnt - p0));
    repeat (20) @(posedge ref_clk);
    check("match_p_count", 8'h01, 8'(p_cnt - p0));
    cnt(8'h00, 8'h80);
    rd(ctm_pkg::FLAG_STATUS_OFS, 8'h02);
    wr(ctm_pkg::FLAG_STATUS_OFS, 8'h03);
    rd(ctm_pkg::FLAG_STATUS_OFS, 8'h00);
    wr(ctm_pkg::CLOCK_ENABLE_CONTROL_OFS, 8'h10);
    wr(ctm_pkg::CLOCK_ENABLE_CONTROL_OFS, 8'h18);
    p0 = p_cnt;
    repeat (1000) @(posedge ref_clk);
    check("match_p_count", 8'h00, 8'(p_cnt - p0));
    repeat (60) @(posedge ref_clk);
    check("match_p_count", 8'h01, 8'(p_cnt - p0));
    check("match_a_count", 8'h00, 8'(a_cnt - a0));
    $display("period and overflow done");
    // Dividers keep their phase across enable, so only a window is exact
    for (int c = 0; c < 6; c++) begin
      wr(ctm_pkg::CLOCK_ENABLE_CONTROL_OFS, {1'b0, 3'(c), 4'h0});
      wr(ctm_pkg::CLOCK_ENABLE_CONTROL_OFS, {1'b0, 3'(c), 4'h8});
      repeat (w[c]) @(posedge ref_clk);
      cnt(8'h30, 8'hF0);
    end
    $display("clock select done");
    repeat (4) @(posedge ref_clk);
    tally_and_finish();
  end
endmodule : ctm_compact_timer_bench

/* verif/ctm_compact_timer_chk.sv */
// Checker: port-level properties of the compact timer
module ctm_compact_timer_chk #(
  parameter int COUNTER_WIDTH = ctm_pkg::COUNTER_WIDTH
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic timer_out,
  input wire logic timer_out_inverted,
  input wire logic match_a_request,
  input wire logic match_p_request
);
  // ----------------------------------------
  // Control shadows, rebuilt from bus writes
  // ----------------------------------------
  logic en_q;
  logic clr_q;
  logic init_q;
  logic cmp_q;
  logic pol_q;
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      en_q <= 1'b0;
    end else if (reg_write && reg_addr == ctm_pkg::CLOCK_ENABLE_CONTROL_OFS) begin
      en_q <= reg_wdata[ctm_pkg::ENABLE_BIT];
    end
  end
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      clr_q <= 1'b0;
      init_q <= 1'b0;
      cmp_q <= 1'b1;
      pol_q <= 1'b0;
    end else if (reg_write && reg_addr == ctm_pkg::MODE_OUTPUT_CONTROL_OFS) begin
      clr_q <= reg_wdata[ctm_pkg::CLEAR_SELECT_BIT];
      init_q <= reg_wdata[ctm_pkg::INITIAL_LEVEL_BIT];
      cmp_q <= reg_wdata[7:6] == ctm_pkg::MODE_COMPARE;
      pol_q <= reg_wdata[ctm_pkg::POLARITY_BIT];
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  a_out_inverse: assert property (timer_out_inverted == ~timer_out)
    else $error("inverted output differs");
  a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
    else $error("read data outside answer cycle");
  a_high_zero: assert property (reg_read && (reg_addr == ctm_pkg::COUNTER_HIGH_OFS ||
    reg_addr == ctm_pkg::MATCH_A_HIGH_OFS) |=> reg_rdata[7:2] == 6'h00)
    else $error("high byte upper bits set");
  a_a_pulse: assert property (match_a_request |=> !match_a_request)
    else $error("A request longer than one cycle");
  a_p_pulse: assert property (match_p_request |=> !match_p_request)
    else $error("P request longer than one cycle");
  a_no_p_clra: assert property (clr_q && $past(clr_q) && $past(clr_q, 2) |-> !match_p_request)
    else $error("P request while A clears");
  a_off_quiet: assert property (!en_q && !$past(en_q) && !$past(en_q, 2) |->
    !match_a_request && !match_p_request)
    else $error("request while switched off");
  a_init_level: assert property ($rose(en_q) && cmp_q |-> ##[1:3] timer_out == (init_q ^ pol_q))
    else $error("output not at initial level");
  c_a_req: cover property (match_a_request);
  c_p_req: cover property (match_p_request);
  c_en_rise: cover property ($rose(en_q));
endmodule : ctm_compact_timer_chk

bind ctm_compact_timer ctm_compact_timer_chk #(.COUNTER_WIDTH(COUNTER_WIDTH)) ctm_compact_timer_chk_i (
  .ref_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
  .timer_out, .timer_out_inverted, .match_a_request, .match_p_request);

/* verif/ctm_pin_model.sv */
// Partner model: external count pin and clock tick sources
module ctm_pin_model (
  input wire logic ref_clk,
  output logic ext_count_input,
  output logic high_clock_tick,
  output logic sub_clock_tick
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] div_q = 2'h0;
  initial begin
    ext_count_input = 1'b0;
  end
  always @(posedge ref_clk) begin
    div_q <= div_q + 2'h1;
  end
  // ----------------------------------------
  // Tick sources, f_H at half rate, sub at quarter
  // ----------------------------------------
  assign high_clock_tick = div_q[0];
  assign sub_clock_tick = (div_q == 2'h3);
  // Idle low between bursts; tail covers the synchroniser latency
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge ref_clk);
      ext_count_input <= ~ext_count_input;
      repeat (4) @(posedge ref_clk);
      ext_count_input <= ~ext_count_input;
      repeat (4) @(posedge ref_clk);
    end
    repeat (4) @(posedge ref_clk);
  endtask : pulses
endmodule : ctm_pin_model

/* verilog/ctm_clock_select.sv */
// Counter clock selection: prescaler taps and synchronised pin edge detect
module ctm_clock_select (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [2:0] clock_select,
  input wire logic run,
  input wire logic high_clock_tick,
  input wire logic sub_clock_tick,
  input wire logic ext_count_input,
  output logic count_tick
);

  // ----------------------------------------
  // Prescaler
  // ----------------------------------------
  logic [ctm_pkg::PRESCALE_WIDTH-1:0] sys_div_q;
  logic [ctm_pkg::PRESCALE_WIDTH-1:0] high_div_q;
  logic [2:0] pin_sync_q;

  function automatic logic div_hit(input logic [ctm_pkg::PRESCALE_WIDTH-1:0] cnt, input int div);
    div_hit = (cnt & ctm_pkg::PRESCALE_WIDTH'(div - 1)) == '0;
  endfunction : div_hit

  // Prescalers idle while off to save power
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sys_div_q <= '0;
    end else if (run) begin
      sys_div_q <= sys_div_q + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      high_div_q <= '0;
    end else if (run && high_clock_tick) begin
      high_div_q <= high_div_q + 1'b1;
    end
  end

  // ----------------------------------------
  // Pin synchroniser, stage 0 read only by stage 1
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_sync_q <= 3'h0;
    end else begin
      pin_sync_q <= {pin_sync_q[1:0], ext_count_input};
    end
  end

  always_comb begin
    case (clock_select)
      ctm_pkg::SEL_SYS_DIV4: count_tick = div_hit(sys_div_q, ctm_pkg::DIV_SYS4);
      ctm_pkg::SEL_SYS: count_tick = 1'b1;
      ctm_pkg::SEL_HIGH_DIV16: count_tick = high_clock_tick && div_hit(high_div_q, ctm_pkg::DIV_HIGH16);
      ctm_pkg::SEL_HIGH_DIV64: count_tick = high_clock_tick && div_hit(high_div_q, ctm_pkg::DIV_HIGH64);
      ctm_pkg::SEL_SUB_A, ctm_pkg::SEL_SUB_B: count_tick = sub_clock_tick;
      ctm_pkg::SEL_PIN_RISE: count_tick = pin_sync_q[1] && !pin_sync_q[2];
      default: count_tick = !pin_sync_q[1] && pin_sync_q[2];
    endcase
  end

endmodule : ctm_clock_select

/* verilog/ctm_compact_timer.sv */
// Compact timer top: registers, 10-bit counter, comparators and flags
//
// The address map and the address-and-strobe port are this design's own decisions.
module ctm_compact_timer #(
  parameter int COUNTER_WIDTH = ctm_pkg::COUNTER_WIDTH
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire logic high_clock_tick,
  input wire logic sub_clock_tick,
  input wire logic ext_count_input,
  output logic timer_out,
  output logic timer_out_inverted,
  output logic match_a_request,
  output logic match_p_request
);

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  logic [7:0] clock_enable_control_q;
  logic [7:0] mode_output_control_q;
  logic [COUNTER_WIDTH-1:0] match_a_value_q;
  logic [7:0] holding_buffer_q;
  logic [7:0] reg_rdata_q;
  logic [COUNTER_WIDTH-1:0] counter_q;
  logic [COUNTER_WIDTH-1:0] counter_d;
  logic enable_prev_q;
  logic match_a_flag_q;
  logic match_p_flag_q;
  logic match_a_request_q;
  logic match_p_request_q;

  logic counter_enable;
  logic count_pause;
  logic [2:0] clock_select;
  logic [ctm_pkg::PERIOD_WIDTH-1:0] period_code;
  logic [1:0] mode_select;
  logic [1:0] pin_action;
  logic output_initial_level;
  logic output_polarity;
  logic period_duty_swap;
  logic clear_select;
  logic enable_rise;
  logic run;
  logic count_tick;
  logic step;
  logic match_a_hit;
  logic match_p_hit;
  logic overflow_hit;
  logic match_a_event;
  logic match_p_event;
  logic clear_now;
  logic pwm_active;
  logic wr_flags;

  assign count_pause = clock_enable_control_q[ctm_pkg::PAUSE_BIT];
  assign clock_select = clock_enable_control_q[ctm_pkg::CLOCK_SELECT_MSB:ctm_pkg::CLOCK_SELECT_LSB];
  assign counter_enable = clock_enable_control_q[ctm_pkg::ENABLE_BIT];
  assign period_code = clock_enable_control_q[ctm_pkg::PERIOD_CODE_MSB:ctm_pkg::PERIOD_CODE_LSB];
  assign mode_select = mode_output_control_q[ctm_pkg::MODE_MSB:ctm_pkg::MODE_LSB];
  assign pin_action = mode_output_control_q[ctm_pkg::PIN_ACTION_MSB:ctm_pkg::PIN_ACTION_LSB];
  assign output_initial_level = mode_output_control_q[ctm_pkg::INITIAL_LEVEL_BIT];
  assign output_polarity = mode_output_control_q[ctm_pkg::POLARITY_BIT];
  assign period_duty_swap = mode_output_control_q[ctm_pkg::DUTY_SWAP_BIT];
  assign clear_select = mode_output_control_q[ctm_pkg::CLEAR_SELECT_BIT];

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      clock_enable_control_q <= ctm_pkg::CONTROL_RESET;
    end else if (reg_write && reg_addr == ctm_pkg::CLOCK_ENABLE_CONTROL_OFS) begin
      clock_enable_control_q <= reg_wdata;
    end
  end

  // Mode changes while running are the software's hazard
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_output_control_q <= ctm_pkg::CONTROL_RESET;
    end else if (reg_write && reg_addr == ctm_pkg::MODE_OUTPUT_CONTROL_OFS) begin
      mode_output_control_q <= reg_wdata;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      match_a_value_q <= '0;
    end else if (reg_write && reg_addr == ctm_pkg::MATCH_A_HIGH_OFS) begin
      match_a_value_q <= {reg_wdata[COUNTER_WIDTH-9:0], holding_buffer_q};
    end
  end

  // One buffer shared by the write and read sequences, as in the part
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      holding_buffer_q <= 8'h00;
    end else if (reg_write && reg_addr == ctm_pkg::MATCH_A_LOW_OFS) begin
      holding_buffer_q <= reg_wdata;
    end else if (reg_read && reg_addr == ctm_pkg::COUNTER_HIGH_OFS) begin
      holding_buffer_q <= counter_q[7:0];
    end else if (reg_read && reg_addr == ctm_pkg::MATCH_A_HIGH_OFS) begin
      holding_buffer_q <= match_a_value_q[7:0];
    end
  end

  // ----------------------------------------
  // Register reads
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata_q <= 8'h00;
    end else if (reg_read) begin
      case (reg_addr)
        ctm_pkg::CLOCK_ENABLE_CONTROL_OFS: reg_rdata_q <= clock_enable_control_q;
        ctm_pkg::MODE_OUTPUT_CONTROL_OFS: reg_rdata_q <= mode_output_control_q;
        ctm_pkg::COUNTER_LOW_OFS, ctm_pkg::MATCH_A_LOW_OFS: reg_rdata_q <= holding_buffer_q;
        ctm_pkg::COUNTER_HIGH_OFS: reg_rdata_q <= {6'h00, counter_q[COUNTER_WIDTH-1:8]};
        ctm_pkg::MATCH_A_HIGH_OFS: reg_rdata_q <= {6'h00, match_a_value_q[COUNTER_WIDTH-1:8]};
        ctm_pkg::FLAG_STATUS_OFS: reg_rdata_q <= {6'h00, match_p_flag_q, match_a_flag_q};
        default: reg_rdata_q <= 8'h00;
      endcase
    end else begin
      reg_rdata_q <= 8'h00;
    end
  end

  assign reg_rdata = reg_rdata_q;

  // ----------------------------------------
  // Clock source
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      enable_prev_q <= 1'b0;
    end else begin
      enable_prev_q <= counter_enable;
    end
  end

  assign enable_rise = counter_enable && !enable_prev_q;
  assign run = counter_enable && !count_pause;

  ctm_clock_select u_clock_select (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .clock_select(clock_select),
    .run(run),
    .high_clock_tick(high_clock_tick),
    .sub_clock_tick(sub_clock_tick),
    .ext_count_input(ext_count_input),
    .count_tick(count_tick)
  );

  assign step = run && count_tick && !enable_rise;

  // ----------------------------------------
  // Comparators
  // ----------------------------------------
  function automatic logic [COUNTER_WIDTH-1:0] next_count(input logic [COUNTER_WIDTH-1:0] value);
    next_count = value + 1'b1;
  endfunction : next_count

  // P period code zero means top bits never match early
  assign match_p_hit = step && period_code != '0 &&
                       next_count(counter_q) == {period_code, 7'h00};
  assign match_a_hit = step && match_a_value_q != '0 && next_count(counter_q) == match_a_value_q;
  assign overflow_hit = step && counter_q == ctm_pkg::COUNTER_MAX;

  always_comb begin
    match_a_event = match_a_hit;
    match_p_event = 1'b0;
    clear_now = 1'b0;
    if (clear_select) begin
      clear_now = match_a_hit || overflow_hit;
    end else begin
      match_p_event = match_p_hit || (period_code == '0 && overflow_hit);
      clear_now = match_p_hit || overflow_hit;
    end
  end

  // PWM: duty from one comparator, period from the other
  assign pwm_active = period_duty_swap ? (counter_q[COUNTER_WIDTH-1:7] < period_code)
                                       : (counter_q < match_a_value_q);

  // ----------------------------------------
  // Counter
  // ----------------------------------------
  always_comb begin
    counter_d = counter_q;
    if (enable_rise) begin
      counter_d = '0;
    end else if (step && clear_now) begin
      counter_d = '0;
    end else if (step) begin
      counter_d = next_count(counter_q);
    end
  end

  // Compare on the next value, so a match clears with no extra count
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      counter_q <= '0;
    end else begin
      counter_q <= counter_d;
    end
  end

  // ----------------------------------------
  // Flags and requests
  // ----------------------------------------
  assign wr_flags = reg_write && reg_addr == ctm_pkg::FLAG_STATUS_OFS;

  // Set wins over a write-one-to-clear in the same cycle
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      match_a_flag_q <= 1'b0;
      match_p_flag_q <= 1'b0;
    end else begin
      match_a_flag_q <= match_a_event || (match_a_flag_q && !(wr_flags && reg_wdata[ctm_pkg::FLAG_A_BIT]));
      match_p_flag_q <= match_p_event || (match_p_flag_q && !(wr_flags && reg_wdata[ctm_pkg::FLAG_P_BIT]));
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      match_a_request_q <= 1'b0;
      match_p_request_q <= 1'b0;
    end else begin
      match_a_request_q <= match_a_event;
      match_p_request_q <= match_p_event;
    end
  end

  assign match_a_request = match_a_request_q;
  assign match_p_request = match_p_request_q;

  // ----------------------------------------
  // Output pins
  // ----------------------------------------
  ctm_output_pin u_output_pin (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .mode_select(mode_select),
    .pin_action(pin_action),
    .output_initial_level(output_initial_level),
    .output_polarity(output_polarity),
    .enable_rise(enable_rise),
    .running(counter_enable),
    .match_a_event(match_a_event),
    .pwm_active(pwm_active),
    .timer_out(timer_out),
    .timer_out_inverted(timer_out_inverted)
  );

endmodule : ctm_compact_timer

/* verilog/ctm_output_pin.sv */
// Output pin level: initial level, compare actions, PWM and polarity
module ctm_output_pin (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [1:0] mode_select,
  input wire logic [1:0] pin_action,
  input wire logic output_initial_level,
  input wire logic output_polarity,
  input wire logic enable_rise,
  input wire logic running,
  input wire logic match_a_event,
  input wire logic pwm_active,
  output logic timer_out,
  output logic timer_out_inverted
);

  // ----------------------------------------
  // Compare output level
  // ----------------------------------------
  logic level_q;
  logic pwm_q;

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      level_q <= 1'b0;
    end else if (enable_rise) begin
      level_q <= output_initial_level;
    end else if (match_a_event && mode_select == ctm_pkg::MODE_COMPARE) begin
      case (pin_action)
        ctm_pkg::ACTION_LOW: level_q <= 1'b0;
        ctm_pkg::ACTION_HIGH: level_q <= 1'b1;
        ctm_pkg::ACTION_TOGGLE: level_q <= ~level_q;
        default: level_q <= level_q;
      endcase
    end
  end

  // PWM level: pin action 00 inactive, 01 active, 10 waveform
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pwm_q <= 1'b0;
    end else begin
      case (pin_action)
        ctm_pkg::ACTION_NONE: pwm_q <= ~output_initial_level;
        ctm_pkg::ACTION_LOW: pwm_q <= output_initial_level;
        ctm_pkg::ACTION_HIGH: pwm_q <= (running && pwm_active) ? output_initial_level : ~output_initial_level;
        default: pwm_q <= pwm_q;
      endcase
    end
  end

  // Timer mode output undefined; it simply holds low
  always_comb begin
    case (mode_select)
      ctm_pkg::MODE_COMPARE: timer_out = level_q ^ output_polarity;
      ctm_pkg::MODE_PWM: timer_out = pwm_q ^ output_polarity;
      default: timer_out = 1'b0;
    endcase
  end

  assign timer_out_inverted = ~timer_out;

endmodule : ctm_output_pin

/* verilog/ctm_pkg.sv */
// Package: register map, field positions and constants of the compact timer
package ctm_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [2:0] CLOCK_ENABLE_CONTROL_OFS = 3'h0;
  localparam logic [2:0] MODE_OUTPUT_CONTROL_OFS = 3'h1;
  localparam logic [2:0] COUNTER_LOW_OFS = 3'h2;
  localparam logic [2:0] COUNTER_HIGH_OFS = 3'h3;
  localparam logic [2:0] MATCH_A_LOW_OFS = 3'h4;
  localparam logic [2:0] MATCH_A_HIGH_OFS = 3'h5;
  localparam logic [2:0] FLAG_STATUS_OFS = 3'h6;

  // ----------------------------------------
  // Field positions, clock enable control
  // ----------------------------------------
  localparam int PAUSE_BIT = 7;
  localparam int CLOCK_SELECT_MSB = 6;
  localparam int CLOCK_SELECT_LSB = 4;
  localparam int ENABLE_BIT = 3;
  localparam int PERIOD_CODE_MSB = 2;
  localparam int PERIOD_CODE_LSB = 0;

  // ----------------------------------------
  // Field positions, mode output control
  // ----------------------------------------
  localparam int MODE_MSB = 7;
  localparam int MODE_LSB = 6;
  localparam int PIN_ACTION_MSB = 5;
  localparam int PIN_ACTION_LSB = 4;
  localparam int INITIAL_LEVEL_BIT = 3;
  localparam int POLARITY_BIT = 2;
  localparam int DUTY_SWAP_BIT = 1;
  localparam int CLEAR_SELECT_BIT = 0;

  // ----------------------------------------
  // Flag status bits
  // ----------------------------------------
  localparam int FLAG_A_BIT = 0;
  localparam int FLAG_P_BIT = 1;

  // ----------------------------------------
  // Reset values and widths
  // ----------------------------------------
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam int COUNTER_WIDTH = 10;
  localparam int PERIOD_WIDTH = 3;
  localparam logic [9:0] COUNTER_MAX = 10'h3FF;

  // ----------------------------------------
  // Encodings
  // ----------------------------------------
  localparam logic [1:0] MODE_COMPARE = 2'h0;
  localparam logic [1:0] MODE_PWM = 2'h2;
  localparam logic [1:0] MODE_TIMER = 2'h3;
  localparam logic [1:0] ACTION_NONE = 2'h0;
  localparam logic [1:0] ACTION_LOW = 2'h1;
  localparam logic [1:0] ACTION_HIGH = 2'h2;
  localparam logic [1:0] ACTION_TOGGLE = 2'h3;
  localparam logic [2:0] SEL_SYS_DIV4 = 3'h0;
  localparam logic [2:0] SEL_SYS = 3'h1;
  localparam logic [2:0] SEL_HIGH_DIV16 = 3'h2;
  localparam logic [2:0] SEL_HIGH_DIV64 = 3'h3;
  localparam logic [2:0] SEL_SUB_A = 3'h4;
  localparam logic [2:0] SEL_SUB_B = 3'h5;
  localparam logic [2:0] SEL_PIN_RISE = 3'h6;
  localparam logic [2:0] SEL_PIN_FALL = 3'h7;

  // ----------------------------------------
  // Prescaler divides
  // ----------------------------------------
  localparam int DIV_SYS4 = 4;
  localparam int DIV_HIGH16 = 16;
  localparam int DIV_HIGH64 = 64;
  localparam int PRESCALE_WIDTH = 6;

endpackage : ctm_pkg
